// ==== rtl/eeprom_access_pkg.sv ====
// Constants shared by the data EEPROM access controller.
// Assumes an 8-bit I/O register port driven by the processor core on mclk.
// Contract
// R1: While armed, setting the program strobe starts programming data at address.
// R2: Strobe without arm changes nothing and starts no programming.
// R3: Arm bit clears by hardware four clocks after software sets it.
// R4: Software polls strobe, waits self-program, loads address/data, arms, strobes.
// R5: No EEPROM programming while flash self-programming is busy.
// R6: Software keeps interrupts disabled across the whole write sequence; t_busy programs address 000 with globalIntEnable set.
// R7: Strobe stays set during programming, cleared by hardware at the end.
// R8: Software polls the strobe until zero before writing the next byte.
// R9: A launched write stalls the CPU for two cycles.
// R10: Read strobe loads the data register from the current address at once.
// R11: A read stalls the CPU for four cycles.
// R12: During a write, reads are refused and the address register holds.
// R13: Programming time is counted in calibrated RC oscillator cycles, 26368; the code counts that for mode 00 only, 14400 for every other mode.
// R14: Mode field selects erase-and-write, erase only, write only; 11 reserved.
// R15: Mode writes ignored while busy; reset clears mode unless busy.
// R16: Ready interrupt asserts continuously while enabled and strobe is clear.
// R17: Data register supplies write data and receives read data.
package eeprom_access_pkg;
   localparam logic [1:0] REG_ADDR_LO = 2'h0;
   localparam logic [1:0] REG_ADDR_HI = 2'h1;
   localparam logic [1:0] REG_DATA = 2'h2;
   localparam logic [1:0] REG_CONTROL = 2'h3;
   localparam int BIT_READ = 0;
   localparam int BIT_PROG = 1;
   localparam int BIT_ARM = 2;
   localparam int BIT_RIE = 3;
   localparam int BIT_MODE_LO = 4;
   localparam int BIT_MODE_HI = 5;
   localparam int ADDR_W = 10;
   localparam int DEPTH = 1024;
   localparam logic [1:0] MODE_ATOMIC = 2'h0;
   localparam logic [1:0] MODE_ERASE = 2'h1;
   localparam logic [1:0] MODE_WRITE = 2'h2;
   localparam logic [2:0] ARM_CYCLES = 3'h4;
   localparam logic [1:0] WRITE_STALL = 2'h2;
   localparam logic [2:0] READ_STALL = 3'h4;
   localparam int ATOMIC_RC_CYCLES = 26368;
   localparam int SPLIT_RC_CYCLES = 14400;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
endpackage

// ==== rtl/eeprom_access_controller.sv ====
// Data EEPROM control logic with byte storage held in flip-flops.
// Assumes one I/O access per cycle; rcTick is a pin-side pulse from the RC oscillator.
`timescale 1ns/100ps
module eeprom_access_controller
   import eeprom_access_pkg::*;
#(
   parameter int ATOMIC_TICKS = ATOMIC_RC_CYCLES,
   parameter int SPLIT_TICKS = SPLIT_RC_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // I/O register port
   input wire logic ioWrite,
   input wire logic ioRead,
   input wire logic [1:0] ioAddr,
   input wire logic [7:0] ioWdata,
   output logic [7:0] ioRdata_r,
   // System status
   input wire logic selfProgramBusy,
   input wire logic globalIntEnable,
   input wire logic rcTick,
   // Core control
   output logic cpuStall_r,
   output logic readyIrq_r
);
   ////////////////////////////////////////////////////////////////////////////
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [7:0] data_r, data_nxt;
   logic [1:0] mode_r, mode_nxt;
   logic rie_r, rie_nxt, arm_r, arm_nxt, prog_nxt;
   // Reset keeps a running write alive, so the busy flag needs a power-up value of its own.
   logic prog_r = 1'b0;
   logic [2:0] armCnt_r, armCnt_nxt, stallCnt_r, stallCnt_nxt;
   logic [14:0] progCnt_r, progCnt_nxt;
   logic [ADDR_W-1:0] progAddr_r, progAddr_nxt;
   logic [7:0] progData_r, progData_nxt;
   logic [1:0] progMode_r, progMode_nxt;
   logic [7:0] mem_r [DEPTH];
   logic rcMeta_r, rcSync_r, rcPrev_r;
   logic [7:0] ioRdata_nxt;
   logic cpuStall_nxt, readyIrq_nxt, tick, ctrlWr, launch, finish;

   assign tick = rcSync_r & ~rcPrev_r;
   assign ctrlWr = ioWrite && ioAddr == REG_CONTROL;
   // Flash self-programming blocks a launch outright.
   assign launch = ctrlWr && ioWdata[BIT_PROG] && arm_r && !prog_r
                   && !selfProgramBusy; // R1 R2 R5
   assign finish = prog_r && tick && progCnt_r == 15'h0; // R13

   always_comb begin
      addr_nxt = addr_r;
      data_nxt = data_r;
      mode_nxt = mode_r;
      rie_nxt = rie_r;
      arm_nxt = arm_r;
      armCnt_nxt = armCnt_r;
      prog_nxt = prog_r;
      progCnt_nxt = progCnt_r;
      progAddr_nxt = progAddr_r;
      progData_nxt = progData_r;
      progMode_nxt = progMode_r;
      stallCnt_nxt = (stallCnt_r != 3'h0) ? stallCnt_r - 3'h1 : 3'h0;
      if (arm_r) begin
         armCnt_nxt = armCnt_r - 3'h1;
         if (armCnt_r == 3'h1) begin
            arm_nxt = 1'b0; // R3
         end
      end
      if (ioWrite && ioAddr == REG_ADDR_LO && !prog_r) begin
         addr_nxt[7:0] = ioWdata; // R12
      end
      if (ioWrite && ioAddr == REG_ADDR_HI && !prog_r) begin
         addr_nxt[ADDR_W-1:8] = ioWdata[ADDR_W-9:0]; // R12
      end
      if (ioWrite && ioAddr == REG_DATA) begin
         data_nxt = ioWdata; // R17
      end
      if (ctrlWr) begin
         rie_nxt = ioWdata[BIT_RIE];
         if (!prog_r) begin
            mode_nxt = ioWdata[BIT_MODE_HI:BIT_MODE_LO]; // R15
         end
         if (ioWdata[BIT_ARM] && !ioWdata[BIT_PROG]) begin
            arm_nxt = 1'b1;
            armCnt_nxt = ARM_CYCLES; // R3
         end
         if (ioWdata[BIT_READ] && !prog_r) begin
            data_nxt = mem_r[addr_r]; // R10 R17
            stallCnt_nxt = READ_STALL; // R11
         end
      end
      if (launch) begin
         prog_nxt = 1'b1; // R7
         arm_nxt = 1'b0;
         progAddr_nxt = addr_r;
         progData_nxt = data_r;
         progMode_nxt = mode_r;
         progCnt_nxt = (mode_r == MODE_ATOMIC) ? 15'(ATOMIC_TICKS - 1)
                                               : 15'(SPLIT_TICKS - 1); // R13 R14
         stallCnt_nxt = {1'b0, WRITE_STALL}; // R9
      end else if (prog_r && tick && progCnt_r != 15'h0) begin
         progCnt_nxt = progCnt_r - 15'h1;
      end
      if (finish) begin
         prog_nxt = 1'b0; // R7
      end
      cpuStall_nxt = stallCnt_nxt != 3'h0;
      readyIrq_nxt = rie_nxt && globalIntEnable && !prog_nxt; // R16
      ioRdata_nxt = 8'h00;
      if (ioRead) begin
         unique case (ioAddr)
            REG_ADDR_LO: ioRdata_nxt = addr_r[7:0];
            REG_ADDR_HI: ioRdata_nxt = {{(16-ADDR_W){1'b0}}, addr_r[ADDR_W-1:8]};
            REG_DATA: ioRdata_nxt = data_r;
            REG_CONTROL: ioRdata_nxt = {2'h0, mode_r, rie_r, arm_r, prog_r, 1'b0};
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Programming survives reset, so the busy state and its counter ignore it.
   always_ff @(posedge mclk) begin
      rcMeta_r <= rcTick;
      rcSync_r <= rcMeta_r;
      rcPrev_r <= rcSync_r;
      progCnt_r <= progCnt_nxt;
      progAddr_r <= progAddr_nxt;
      progData_r <= progData_nxt;
      progMode_r <= progMode_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      if (reset) begin
         prog_r <= prog_r & ~finish;
         mode_r <= prog_r ? mode_r : MODE_ATOMIC; // R15
         rie_r <= 1'b0;
         arm_r <= 1'b0;
         armCnt_r <= 3'h0;
         stallCnt_r <= 3'h0;
         cpuStall_r <= 1'b0;
         readyIrq_r <= 1'b0;
         ioRdata_r <= 8'h00;
      end else begin
         prog_r <= prog_nxt;
         mode_r <= mode_nxt;
         rie_r <= rie_nxt;
         arm_r <= arm_nxt;
         armCnt_r <= armCnt_nxt;
         stallCnt_r <= stallCnt_nxt;
         cpuStall_r <= cpuStall_nxt;
         readyIrq_r <= readyIrq_nxt;
         ioRdata_r <= ioRdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   for (genvar i = 0; i < DEPTH; i++) begin : gCell
      always_ff @(posedge mclk) begin
         if (finish && progAddr_r == ADDR_W'(i)) begin
            unique case (progMode_r)
               MODE_ERASE: mem_r[i] <= ERASED_BYTE; // R14
               MODE_WRITE: mem_r[i] <= mem_r[i] & progData_r; // R14
               default: mem_r[i] <= progData_r; // R1 R14
            endcase
         end
      end
   end
endmodule // eeprom_access_controller

// ==== testbench/eeprom_access_properties.sv ====
// Port assertions for the EEPROM access controller.
// Bound to every controller; sees its ports only.
`timescale 1ns/100ps
module eeprom_access_properties import eeprom_access_pkg::*; (
   // Controller ports
   input wire logic mclk, reset, ioWrite, ioRead,
   input wire logic selfProgramBusy, globalIntEnable, cpuStall_r, readyIrq_r,
   input wire logic [1:0] ioAddr,
   input wire logic [7:0] ioWdata, ioRdata_r
);
   logic [2:0] armCnt_r;
   wire ctl = ioWrite && ioAddr == REG_CONTROL;
   wire go = ctl && ioWdata[1:0] == 2'h2;
   wire launch = go && armCnt_r > 3'h1 && !selfProgramBusy;
   // Only the sure ends of the arm window are judged.
   always_ff @(posedge mclk)
      armCnt_r <= reset ? 3'h0 : ctl && ioWdata[2:1] == 2'h2 ? ARM_CYCLES
         : armCnt_r - {2'h0, |armCnt_r};
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   a_stall_cause: assert property ($rose(cpuStall_r) |-> $past(ctl))
      else $error("stray stall");
   a_write_stall: assert property ($rose(cpuStall_r) && $past(ioWdata[1])
      |-> cpuStall_r[*2] ##1 !cpuStall_r) else $error("write stall");
   a_read_stall: assert property ($rose(cpuStall_r) && $past(ioWdata[0])
      |-> cpuStall_r[*4] ##1 !cpuStall_r) else $error("read stall");
   a_armed_launch: assert property (launch |=> cpuStall_r)
      else $error("no launch");
   a_launch_refused: assert property (go && (armCnt_r == 3'h0 || selfProgramBusy)
      |=> !cpuStall_r) else $error("bad launch");
   a_irq_gate: assert property (readyIrq_r |-> $past(globalIntEnable))
      else $error("irq gate");
   a_irq_busy: assert property (launch |-> ##2 !readyIrq_r)
      else $error("irq busy");
   a_rdata_idle: assert property (!$past(ioRead) |-> ioRdata_r == 8'h00)
      else $error("rdata");
   cover property (launch);
   cover property ($rose(readyIrq_r));
   cover property (go && selfProgramBusy);
endmodule // eeprom_access_properties
bind eeprom_access_controller eeprom_access_properties i_props (.*);

// ==== testbench/core.sv ====
// Processor core model: I/O accesses and a free running RC tick.
// Assumes the block samples requests on the rising mclk edge.
`timescale 1ns/100ps
module core import eeprom_access_pkg::*; (
   // Requests
   output logic ioWrite = '0, ioRead = '0, rcTick = '0,
   output logic [1:0] ioAddr = '0,
   output logic [7:0] ioWdata = '0,
   // Answers
   input wire logic mclk, cpuStall_r, selfProgramBusy,
   input wire logic [7:0] ioRdata_r
);
   always #83 rcTick = ~rcTick;
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk) #1;
      {ioWrite, ioAddr, ioWdata} = {1'h1, a, d};
      @(posedge mclk) #1;
      {ioWrite, ioWdata} = {1'h0, ~d};
      // A stalled core issues nothing.
      while (cpuStall_r) @(posedge mclk) #1;
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge mclk) #1;
      {ioRead, ioAddr} = {1'h1, a};
      @(posedge mclk) #1;
      ioRead = 1'h0;
      d = ioRdata_r;
   endtask
   task automatic idle;
      logic [7:0] s;
      s = 8'h02;
      while (s[1]) rd(REG_CONTROL, s);
      wait (!selfProgramBusy);
   endtask
   task automatic at(input logic [9:0] a);
      idle();
      wr(REG_ADDR_LO, a[7:0]);
      wr(REG_ADDR_HI, {6'h0, a[9:8]});
   endtask
   task automatic prog(input logic [9:0] a, input logic [7:0] d, m);
      at(a);
      wr(REG_DATA, d);
      wr(REG_CONTROL, m | 8'h04);
      wr(REG_CONTROL, m | 8'h02);
   endtask
endmodule // core

// ==== testbench/eeprom_access_controller_tb.sv ====
// Bench for the EEPROM access controller, one task per scenario.
// Assumes the core model and the bound checker.
`timescale 1ns/100ps
module eeprom_access_controller_tb import eeprom_access_pkg::*;;
   logic mclk = '0, reset = '1, selfProgramBusy = '0, globalIntEnable = '0;
   logic ioWrite, ioRead, rcTick, cpuStall_r, readyIrq_r;
   logic [1:0] ioAddr;
   logic [7:0] ioWdata, ioRdata_r, v;
   logic [7:0] dat[4] = '{8'h5a, 8'h00, 8'h3c, 8'h0f};
   logic [7:0] md[4] = '{8'h00, 8'h10, 8'h20, 8'h20};
   logic [7:0] ex[4] = '{8'h5a, ERASED_BYTE, 8'h3c, 8'h0c};
   int n_mismatch = 0, check_count = 0;
   always #20 mclk = ~mclk;
   eeprom_access_controller #(.ATOMIC_TICKS(8), .SPLIT_TICKS(2))
      i_eeprom_access_controller (.*);
   core i_core (.*);
   task automatic chk(input logic [7:0] s, e);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %0t got %h", $time, s);
      end
   endtask
   task automatic finish_test;
      $display("%0d checks %0d bad", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic t_modes;
      for (int i = 0; i < 4; i++) begin
         i_core.prog(10'h2a5, dat[i], md[i]);
         i_core.rd(REG_CONTROL, v);
         chk(v & 8'h06, 8'h02);
         i_core.at(10'h2a5);
         i_core.wr(REG_CONTROL, 8'h01);
         i_core.rd(REG_DATA, v);
         chk(v, ex[i]);
      end
      $display("modes done");
   endtask
   task automatic t_refuse;
      i_core.wr(REG_CONTROL, 8'h02);
      i_core.wr(REG_CONTROL, 8'h04);
      repeat (6) @(posedge mclk);
      i_core.rd(REG_CONTROL, v);
      chk(v, 8'h00);
      selfProgramBusy = '1;
      i_core.wr(REG_CONTROL, 8'h04);
      i_core.wr(REG_CONTROL, 8'h02);
      i_core.rd(REG_CONTROL, v);
      chk(v & 8'h02, 8'h00);
      selfProgramBusy = '0;
      $display("refuse done");
   endtask
   task automatic t_busy;
      i_core.prog(10'h155, 8'ha7, 8'h00);
      i_core.wr(REG_ADDR_LO, 8'h00);
      i_core.wr(REG_CONTROL, 8'h13);
      i_core.rd(REG_CONTROL, v);
      chk(v, 8'h02);
      // A reset in mid-write must leave the write running to its end.
      @(posedge mclk) #1;
      reset = '1;
      @(posedge mclk) #1;
      reset = '0;
      i_core.rd(REG_CONTROL, v);
      chk(v, 8'h02);
      i_core.idle();
      i_core.wr(REG_CONTROL, 8'h01);
      i_core.rd(REG_DATA, v);
      chk(v, 8'ha7);
      globalIntEnable = '1;
      i_core.prog(10'h000, 8'h11, 8'h08);
      chk({7'h0, readyIrq_r}, 8'h00);
      i_core.idle();
      @(posedge mclk) #1;
      chk({7'h0, readyIrq_r}, 8'h01);
      $display("busy done");
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      #1 reset = '0;
      t_modes();
      t_refuse();
      t_busy();
      finish_test();
   end
   initial begin
      #100000;
      n_mismatch++;
      finish_test();
   end
endmodule // eeprom_access_controller_tb
